// ==== verilog/rpeq_top.sv ====
// What this block does
// - Bypass applies manual setting from two fields
// - Mode one: lock waits for adaptation done
// - Mode zero: lock from detector only
// - Adaptive value never exceeds four-bit ceiling
// - Floor enable starts adaptation at floor
// - Registers per port, writes steered by port enables, reads by port select
// - Encoding error raises enabled interrupt
// - Control channel sequence error raises interrupt
// - Control channel checksum error raises interrupt
// - Line length change raises enabled interrupt
// - Line count change raises enabled interrupt
// - Receive buffer overflow raises enabled interrupt
// - Camera receiver error raises enabled interrupt
// - Link parity error raises enabled interrupt
// - Port valid change raises enabled interrupt
// - Lock change raises enabled interrupt
// - All interrupt enables reset to zero
// - Condition latched until status read clears
`include "rpeq_map.svh"
`default_nettype none
module rpeq_top (
	input wire logic i_clk_sys, // Core clock, 250 MHz
	input wire logic i_rst_n, // Async reset, low
	input wire logic i_reg_wr, // Register write strobe
	input wire logic i_reg_rd, // Register read strobe
	input wire logic [7:0] i_reg_addr, // Register offset
	input wire logic [7:0] i_reg_wdata, // Write data
	output logic [7:0] o_reg_rdata, // Read data, next cycle
	input wire logic [`RPEQ_NPORT-1:0] i_port_wr_en, // Ports taking writes
	input wire logic i_port_rd_sel, // Port answering reads
	input wire logic [`RPEQ_NPORT-1:0] i_floor_start_enable, // Floor start per port
	input wire logic [`RPEQ_NPORT-1:0] i_lock_detect, // Raw lock detector
	input wire logic [`RPEQ_NPORT-1:0] i_adapt_done, // Adaptation settled
	input wire logic [`RPEQ_NPORT-1:0] i_port_valid, // Port valid status
	input wire logic [`RPEQ_NPORT*6-1:0] i_adapt_value, // Engine setting per port
	input wire rpeq_pkg::rpeq_evt_t [`RPEQ_NPORT-1:0] i_evt, // Error events per port
	output logic [`RPEQ_NPORT-1:0] o_rx_lock, // Qualified lock
	output logic [`RPEQ_NPORT-1:0] o_adapt_run, // Adaptation allowed
	output logic [`RPEQ_NPORT*6-1:0] o_eq_setting, // Applied equalizer
	output logic [`RPEQ_NPORT*4-1:0] o_eq_start, // Adaptation start code
	output logic [`RPEQ_NPORT*4-1:0] o_eq_ceiling, // Adaptation ceiling
	output logic o_irq // Device interrupt
);
	import rpeq_pkg::*;

	rpeq_cfg_t cfg [`RPEQ_NPORT];
	logic [`RPEQ_NFLG-1:0] flag [`RPEQ_NPORT];
	logic [`RPEQ_NFLG-1:0] set_vec [`RPEQ_NPORT];
	logic [`RPEQ_NFLG-1:0] clr_vec [`RPEQ_NPORT];
	logic [`RPEQ_NFLG-1:0] ena_vec [`RPEQ_NPORT];
	logic [`RPEQ_NPORT-1:0] port_pend;
	logic [`RPEQ_NPORT-1:0] lock_now;
	logic [`RPEQ_NPORT-1:0] lock_d;
	logic [`RPEQ_NPORT-1:0] lock_q;
	logic [`RPEQ_NPORT-1:0] valid_d;
	logic [`RPEQ_NPORT-1:0] valid_q;
	logic [`RPEQ_NPORT*6-1:0] eq_d;
	logic [`RPEQ_NPORT*6-1:0] eq_q;
	logic [`RPEQ_NPORT*4-1:0] start_d;
	logic [`RPEQ_NPORT*4-1:0] start_q;
	logic [`RPEQ_NPORT-1:0] run_d;
	logic [`RPEQ_NPORT-1:0] run_q;
	logic rd_sts1;
	logic rd_sts2;
	logic rd_csi;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic irq_d;
	logic irq_q;

	// Status reads decoded once, then steered to the selected port
	always_comb begin
		rd_sts1 = i_reg_rd && (i_reg_addr == `RPEQ_OFS_RX_PORT_STATUS_ONE);
		rd_sts2 = i_reg_rd && (i_reg_addr == `RPEQ_OFS_RX_PORT_STATUS_TWO);
		rd_csi = i_reg_rd && (i_reg_addr == `RPEQ_OFS_CAMERA_RX_ERROR_STATUS);
	end

	genvar p;
	generate
		for (p = 0; p < `RPEQ_NPORT; p++) begin : g_port
			logic sel_rd;
			logic [5:0] adapt_in;
			logic [5:0] ceil_ext;
			logic [5:0] manual;

			rpeq_port_regs u_regs (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(i_rst_n),
				.i_wr(i_reg_wr & i_port_wr_en[p]),
				.i_addr(i_reg_addr),
				.i_wdata(i_reg_wdata),
				.o_cfg(cfg[p])
			);

			always_comb begin
				sel_rd = (i_port_rd_sel == 1'(p));
				adapt_in = i_adapt_value[p*6 +: 6];
				ceil_ext = {2'h0, cfg[p].eq_adapt_limits.equalizer_ceiling};
				manual = {cfg[p].eq_manual_override.manual_eq_upper_bits,
					cfg[p].eq_manual_override.manual_eq_lower_bits};
			end

			// Lock qualification
			always_comb begin
				if (cfg[p].eq_manual_override.lock_waits_for_adaptation) begin
					lock_now[p] = i_lock_detect[p] & i_adapt_done[p];
				end else begin
					lock_now[p] = i_lock_detect[p];
				end
				lock_d[p] = lock_now[p];
				valid_d[p] = i_port_valid[p];
			end

			// Equalizer steering; clamp guards a runaway engine
			always_comb begin
				run_d[p] = ~cfg[p].eq_manual_override.equalizer_adapt_disable;
				if (cfg[p].eq_manual_override.equalizer_adapt_disable) begin
					eq_d[p*6 +: 6] = manual;
				end else if (adapt_in > ceil_ext) begin
					eq_d[p*6 +: 6] = ceil_ext;
				end else begin
					eq_d[p*6 +: 6] = adapt_in;
				end
				if (i_floor_start_enable[p]) begin
					start_d[p*4 +: 4] = cfg[p].eq_adapt_limits.equalizer_start_floor;
				end else begin
					start_d[p*4 +: 4] = 4'h0;
				end
			end

			// Conditions seen this cycle
			always_comb begin
				set_vec[p] = '0;
				set_vec[p][`RPEQ_FLG_ENC] = i_evt[p].encoding_error;
				set_vec[p][`RPEQ_FLG_SEQ] = i_evt[p].ctrl_chan_sequence_error;
				set_vec[p][`RPEQ_FLG_CRC] = i_evt[p].ctrl_chan_checksum_error;
				set_vec[p][`RPEQ_FLG_LEN] = i_evt[p].line_length_change;
				set_vec[p][`RPEQ_FLG_CNT] = i_evt[p].line_count_change;
				set_vec[p][`RPEQ_FLG_BUF] = i_evt[p].rx_buffer_overflow;
				set_vec[p][`RPEQ_FLG_CSI] = i_evt[p].camera_rx_error;
				set_vec[p][`RPEQ_FLG_PAR] = i_evt[p].link_parity_error;
				set_vec[p][`RPEQ_FLG_VALID] = i_port_valid[p] ^ valid_q[p];
				set_vec[p][`RPEQ_FLG_LOCK] = lock_now[p] ^ lock_q[p];
			end

			// Each status register clears only the conditions it reports
			always_comb begin
				clr_vec[p] = '0;
				clr_vec[p][`RPEQ_FLG_LOCK] = rd_sts1 & sel_rd;
				clr_vec[p][`RPEQ_FLG_VALID] = rd_sts1 & sel_rd;
				clr_vec[p][`RPEQ_FLG_PAR] = rd_sts1 & sel_rd;
				clr_vec[p][`RPEQ_FLG_SEQ] = rd_sts1 & sel_rd;
				clr_vec[p][`RPEQ_FLG_CRC] = rd_sts1 & sel_rd;
				clr_vec[p][`RPEQ_FLG_ENC] = rd_sts2 & sel_rd;
				clr_vec[p][`RPEQ_FLG_LEN] = rd_sts2 & sel_rd;
				clr_vec[p][`RPEQ_FLG_CNT] = rd_sts2 & sel_rd;
				clr_vec[p][`RPEQ_FLG_BUF] = rd_sts2 & sel_rd;
				clr_vec[p][`RPEQ_FLG_CSI] = rd_csi & sel_rd;
			end

			// Enables laid out in condition order
			always_comb begin
				ena_vec[p] = {cfg[p].port_irq_mask_upper[2:0],
					cfg[p].port_irq_mask_lower[6:0]};
				port_pend[p] = |(flag[p] & ena_vec[p]);
			end

			rpeq_irq_latch u_latch (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(i_rst_n),
				.i_set(set_vec[p]),
				.i_clr(clr_vec[p]),
				.o_flag(flag[p])
			);
		end
	endgenerate

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_q <= '0;
			valid_q <= '0;
			eq_q <= '0;
			start_q <= '0;
			run_q <= '1;
		end else begin
			lock_q <= lock_d;
			valid_q <= valid_d;
			eq_q <= eq_d;
			start_q <= start_d;
			run_q <= run_d;
		end
	end

	// Read mux; unmapped offsets answer zero
	always_comb begin
		rdata_d = rdata_q;
		if (i_reg_rd) begin
			case (i_reg_addr)
				`RPEQ_OFS_EQ_MANUAL_OVERRIDE: begin
					rdata_d = cfg[i_port_rd_sel].eq_manual_override;
				end
				`RPEQ_OFS_EQ_ADAPT_LIMITS: begin
					rdata_d = cfg[i_port_rd_sel].eq_adapt_limits;
				end
				`RPEQ_OFS_RESERVED_SLOT_D6: rdata_d = cfg[i_port_rd_sel].reserved_slot_d6;
				`RPEQ_OFS_RESERVED_SLOT_D7: rdata_d = cfg[i_port_rd_sel].reserved_slot_d7;
				`RPEQ_OFS_PORT_IRQ_MASK_UPPER: begin
					rdata_d = cfg[i_port_rd_sel].port_irq_mask_upper;
				end
				`RPEQ_OFS_PORT_IRQ_MASK_LOWER: begin
					rdata_d = cfg[i_port_rd_sel].port_irq_mask_lower;
				end
				`RPEQ_OFS_RX_PORT_STATUS_ONE: begin
					rdata_d = {2'h0, lock_q[i_port_rd_sel],
						flag[i_port_rd_sel][`RPEQ_FLG_CRC],
						flag[i_port_rd_sel][`RPEQ_FLG_SEQ],
						flag[i_port_rd_sel][`RPEQ_FLG_PAR],
						flag[i_port_rd_sel][`RPEQ_FLG_VALID],
						flag[i_port_rd_sel][`RPEQ_FLG_LOCK]};
				end
				`RPEQ_OFS_RX_PORT_STATUS_TWO: begin
					rdata_d = {4'h0, flag[i_port_rd_sel][`RPEQ_FLG_BUF],
						flag[i_port_rd_sel][`RPEQ_FLG_CNT],
						flag[i_port_rd_sel][`RPEQ_FLG_LEN],
						flag[i_port_rd_sel][`RPEQ_FLG_ENC]};
				end
				`RPEQ_OFS_CAMERA_RX_ERROR_STATUS: begin
					rdata_d = {7'h0, flag[i_port_rd_sel][`RPEQ_FLG_CSI]};
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Registered so the pin never glitches between ports
	always_comb begin
		irq_d = |port_pend;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	always_comb begin
		o_reg_rdata = rdata_q;
		o_irq = irq_q;
		o_rx_lock = lock_q;
		o_adapt_run = run_q;
		o_eq_setting = eq_q;
		o_eq_start = start_q;
		o_eq_ceiling = {cfg[1].eq_adapt_limits.equalizer_ceiling,
			cfg[0].eq_adapt_limits.equalizer_ceiling};
	end
endmodule
`default_nettype wire

// ==== inc/rpeq_map.svh ====
`ifndef RPEQ_MAP_SVH
`define RPEQ_MAP_SVH

// Receive ports served by this bank
`define RPEQ_NPORT 2

// Per-port register offsets
`define RPEQ_OFS_EQ_MANUAL_OVERRIDE 8'hd4
`define RPEQ_OFS_EQ_ADAPT_LIMITS 8'hd5
`define RPEQ_OFS_RESERVED_SLOT_D6 8'hd6
`define RPEQ_OFS_RESERVED_SLOT_D7 8'hd7
`define RPEQ_OFS_PORT_IRQ_MASK_UPPER 8'hd8
`define RPEQ_OFS_PORT_IRQ_MASK_LOWER 8'hd9

// Status registers whose read clears latched conditions
`define RPEQ_OFS_RX_PORT_STATUS_ONE 8'h4d
`define RPEQ_OFS_RX_PORT_STATUS_TWO 8'h4e
`define RPEQ_OFS_CAMERA_RX_ERROR_STATUS 8'h7a

// Reset values
`define RPEQ_RST_EQ_MANUAL_OVERRIDE 8'h60
`define RPEQ_RST_EQ_ADAPT_LIMITS 8'hf2
`define RPEQ_RST_RESERVED_SLOT 8'h00
`define RPEQ_RST_PORT_IRQ_MASK 8'h00

// Writable bits of the upper mask register
`define RPEQ_MASK_UPPER_WR 8'h07

// Positions in the ten-bit condition vector
`define RPEQ_FLG_LOCK 0
`define RPEQ_FLG_VALID 1
`define RPEQ_FLG_PAR 2
`define RPEQ_FLG_CSI 3
`define RPEQ_FLG_BUF 4
`define RPEQ_FLG_CNT 5
`define RPEQ_FLG_LEN 6
`define RPEQ_FLG_CRC 7
`define RPEQ_FLG_SEQ 8
`define RPEQ_FLG_ENC 9
`define RPEQ_NFLG 10

`endif

// ==== inc/rpeq_pkg.sv ====
`default_nettype none
package rpeq_pkg;

	typedef struct packed {
		logic [2:0] manual_eq_upper_bits;
		logic lock_waits_for_adaptation;
		logic [2:0] manual_eq_lower_bits;
		logic equalizer_adapt_disable;
	} rpeq_override_t;

	typedef struct packed {
		logic [3:0] equalizer_ceiling;
		logic [3:0] equalizer_start_floor;
	} rpeq_limits_t;

	typedef struct packed {
		rpeq_override_t eq_manual_override;
		rpeq_limits_t eq_adapt_limits;
		logic [7:0] reserved_slot_d6;
		logic [7:0] reserved_slot_d7;
		logic [7:0] port_irq_mask_upper;
		logic [7:0] port_irq_mask_lower;
	} rpeq_cfg_t;

	// One-cycle error events from a receive port
	typedef struct packed {
		logic encoding_error;
		logic ctrl_chan_sequence_error;
		logic ctrl_chan_checksum_error;
		logic line_length_change;
		logic line_count_change;
		logic rx_buffer_overflow;
		logic camera_rx_error;
		logic link_parity_error;
	} rpeq_evt_t;

endpackage
`default_nettype wire

// ==== verilog/rpeq_port_regs.sv ====
`include "rpeq_map.svh"
`default_nettype none
module rpeq_port_regs (
	input wire logic i_clk_sys, // Core clock
	input wire logic i_rst_n, // Async reset, low
	input wire logic i_wr, // Write strobe for this port
	input wire logic [7:0] i_addr, // Register offset
	input wire logic [7:0] i_wdata, // Write data
	output rpeq_pkg::rpeq_cfg_t o_cfg // Stored settings
);
	import rpeq_pkg::*;

	rpeq_cfg_t cfg_d;
	rpeq_cfg_t cfg_q;

	always_comb begin
		cfg_d = cfg_q;
		if (i_wr) begin
			case (i_addr)
				`RPEQ_OFS_EQ_MANUAL_OVERRIDE: cfg_d.eq_manual_override = i_wdata;
				`RPEQ_OFS_EQ_ADAPT_LIMITS: cfg_d.eq_adapt_limits = i_wdata;
				`RPEQ_OFS_RESERVED_SLOT_D6: cfg_d.reserved_slot_d6 = i_wdata;
				`RPEQ_OFS_RESERVED_SLOT_D7: cfg_d.reserved_slot_d7 = i_wdata;
				`RPEQ_OFS_PORT_IRQ_MASK_UPPER: begin
					cfg_d.port_irq_mask_upper = i_wdata & `RPEQ_MASK_UPPER_WR;
				end
				`RPEQ_OFS_PORT_IRQ_MASK_LOWER: cfg_d.port_irq_mask_lower = i_wdata;
				default: cfg_d = cfg_q;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_q.eq_manual_override <= `RPEQ_RST_EQ_MANUAL_OVERRIDE;
			cfg_q.eq_adapt_limits <= `RPEQ_RST_EQ_ADAPT_LIMITS;
			cfg_q.reserved_slot_d6 <= `RPEQ_RST_RESERVED_SLOT;
			cfg_q.reserved_slot_d7 <= `RPEQ_RST_RESERVED_SLOT;
			cfg_q.port_irq_mask_upper <= `RPEQ_RST_PORT_IRQ_MASK;
			cfg_q.port_irq_mask_lower <= `RPEQ_RST_PORT_IRQ_MASK;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	assign o_cfg = cfg_q;
endmodule
`default_nettype wire

// ==== verilog/rpeq_irq_latch.sv ====
`include "rpeq_map.svh"
`default_nettype none
module rpeq_irq_latch (
	input wire logic i_clk_sys, // Core clock
	input wire logic i_rst_n, // Async reset, low
	input wire logic [`RPEQ_NFLG-1:0] i_set, // Condition seen this cycle
	input wire logic [`RPEQ_NFLG-1:0] i_clr, // Clearing read this cycle
	output logic [`RPEQ_NFLG-1:0] o_flag // Latched conditions
);
	logic [`RPEQ_NFLG-1:0] flag_d;
	logic [`RPEQ_NFLG-1:0] flag_q;

	genvar g;
	generate
		for (g = 0; g < `RPEQ_NFLG; g++) begin : g_bit
			// Set beats clear so an event in the read cycle survives
			always_comb begin
				flag_d[g] = i_set[g] | (flag_q[g] & ~i_clr[g]);
			end
		end
	endgenerate

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign o_flag = flag_q;
endmodule
`default_nettype wire

// ==== bench/rpeq_top_properties.sv ====
`default_nettype none
module rpeq_top_properties (
	input wire logic i_clk_sys, // Clock
	input wire logic i_rst_n, // Reset, low
	input wire logic i_reg_wr, // Write
	input wire logic i_reg_rd, // Read
	input wire logic [7:0] i_reg_addr, // Offset
	input wire logic [7:0] o_reg_rdata, // Read data
	input wire logic [1:0] i_lock_detect, // Raw lock
	input wire logic [1:0] i_adapt_done, // Settled
	input wire logic [11:0] i_adapt_value, // Engine code
	input wire logic [1:0] o_rx_lock, // Lock
	input wire logic [1:0] o_adapt_run, // Adapting
	input wire logic [11:0] o_eq_setting, // Applied code
	input wire logic [7:0] o_eq_ceiling, // Ceilings
	input wire logic o_irq // Interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	wire logic [5:0] ceil0 = {2'h0, o_eq_ceiling[3:0]};
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	property p_lock_det;
		o_rx_lock[0] |-> $past(i_lock_detect[0]);
	endproperty
	a_lock_det: assert property (p_lock_det) else $error("lock w/o detect");
	property p_lock_rdy;
		$past(i_rst_n && i_lock_detect[0] && i_adapt_done[0]) |-> o_rx_lock[0];
	endproperty
	a_lock_rdy: assert property (p_lock_rdy) else $error("lock missing");
	// Reset cycle is skipped: setting still holds its reset value there
	property p_clamp;
		$past(i_rst_n) && o_adapt_run[0] |-> o_eq_setting[5:0] ==
			($past(i_adapt_value[5:0]) > $past(ceil0) ? $past(ceil0) : $past(i_adapt_value[5:0]));
	endproperty
	a_clamp: assert property (p_clamp) else $error("ceiling exceeded");
	property p_rd_hold;
		!$past(i_reg_rd) |-> $stable(o_reg_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_unmapped;
		$past(i_reg_rd && i_reg_addr < 8'h4d) |-> o_reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
	property p_irq_fall;
		$fell(o_irq) |-> $past(i_reg_rd, 2) || $past(i_reg_wr, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
	property p_irq_rst;
		$rose(i_rst_n) |-> !o_irq ##1 !o_irq;
	endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
	property p_run_rst;
		$rose(i_rst_n) |-> o_adapt_run == 2'h3;
	endproperty
	a_run_rst: assert property (p_run_rst) else $error("adapt off at reset");
endmodule
bind rpeq_top rpeq_top_properties u_props (.i_clk_sys, .i_rst_n, .i_reg_wr, .i_reg_rd,
	.i_reg_addr, .o_reg_rdata, .i_lock_detect, .i_adapt_done, .i_adapt_value,
	.o_rx_lock, .o_adapt_run, .o_eq_setting, .o_eq_ceiling, .o_irq);
`default_nettype wire

// ==== bench/rpeq_rx_model.sv ====
`default_nettype none
module rpeq_rx_model (
	input wire logic i_clk_sys, // Clock
	output logic [1:0] o_lock_detect, // Raw lock
	output logic [1:0] o_adapt_done, // Settled
	output logic [1:0] o_port_valid, // Port valid
	output logic [11:0] o_adapt_value, // Engine code
	output var rpeq_pkg::rpeq_evt_t [1:0] o_evt // Error events
);
	timeunit 1ns;
	timeprecision 1ps;
	import rpeq_pkg::*;
	initial begin
		o_lock_detect = 2'h0;
		o_adapt_done = 2'h0;
		o_port_valid = 2'h0;
		o_adapt_value = 12'h000;
		o_evt = '0;
	end
	// Index 0-7 is an event bit, 8 flips lock, 9 flips port valid
	task automatic pulse(input int b);
		@(posedge i_clk_sys);
		if (b < 8) begin
			o_evt[0][b] <= 1'b1;
		end else if (b == 8) begin
			o_lock_detect[0] <= ~o_lock_detect[0];
		end else begin
			o_port_valid[0] <= ~o_port_valid[0];
		end
		@(posedge i_clk_sys);
		o_evt <= '0;
	endtask
	task automatic set_link(input logic lk, input logic dn, input logic [5:0] v);
		@(posedge i_clk_sys);
		o_lock_detect[0] <= lk;
		o_adapt_done[0] <= dn;
		o_adapt_value[5:0] <= v;
	endtask
endmodule
`default_nettype wire

// ==== bench/rpeq_top_tb_top.sv ====
`default_nettype none
module rpeq_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rpeq_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sel = 1'b0, irq;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, st, cei;
	logic [1:0] wen = 2'h0, fse = 2'h0, lk, dn, pv, rxl, run;
	logic [11:0] av, eqs;
	rpeq_evt_t [1:0] ev;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	localparam logic [7:0] rst_val [6] = '{8'h60, 8'hf2, 8'h00, 8'h00, 8'h00, 8'h00};
	// Per event: enable bit, status register, status bit
	localparam logic [2:0] en_bit [10] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6,
		3'h0, 3'h1, 3'h2, 3'h0, 3'h1};
	localparam logic [7:0] st_addr [10] = '{8'h4d, 8'h7a, 8'h4e, 8'h4e, 8'h4e,
		8'h4d, 8'h4d, 8'h4e, 8'h4d, 8'h4d};
	localparam logic [2:0] st_bit [10] = '{3'h2, 3'h0, 3'h3, 3'h2, 3'h1,
		3'h4, 3'h3, 3'h0, 3'h0, 3'h1};
	rpeq_top DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_port_wr_en(wen),
		.i_port_rd_sel(sel), .i_floor_start_enable(fse), .i_lock_detect(lk),
		.i_adapt_done(dn), .i_port_valid(pv), .i_adapt_value(av), .i_evt(ev),
		.o_rx_lock(rxl), .o_adapt_run(run), .o_eq_setting(eqs), .o_eq_start(st),
		.o_eq_ceiling(cei), .o_irq(irq));
	rpeq_rx_model m (.i_clk_sys(clk), .o_lock_detect(lk), .o_adapt_done(dn),
		.o_port_valid(pv), .o_adapt_value(av), .o_evt(ev));
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr8(input logic [1:0] pe, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		wen <= pe;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic p, input logic [7:0] a, input logic [7:0] mk,
		input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		sel <= p;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		#1 chk(rdata & mk, e);
	endtask
	// Covers the two-edge event-to-interrupt path with margin
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdc(1'b0, 8'hd4 + 8'(i), 8'hff, rst_val[i]);
		end
		rdc(1'b0, 8'h10, 8'hff, 8'h00);
		chk(st, 8'h00);
		for (int k = 0; k < 10; k++) begin
			m.pulse(k);
			settle();
			chk(irq, 1'b0);
			wr8(2'h1, (k inside {[5:7]}) ? 8'hd8 : 8'hd9, 8'h01 << en_bit[k]);
			settle();
			chk(irq, 1'b1);
			rdc(1'b0, st_addr[k], 8'h01 << st_bit[k], 8'h01 << st_bit[k]);
			settle();
			chk(irq, 1'b0);
			wr8(2'h1, (k inside {[5:7]}) ? 8'hd8 : 8'hd9, 8'h00);
		end
		wr8(2'h1, 8'hd8, 8'hff);
		rdc(1'b0, 8'hd8, 8'hff, 8'h07);
		wr8(2'h2, 8'hd5, 8'h52);
		rdc(1'b0, 8'hd5, 8'hff, 8'hf2);
		rdc(1'b1, 8'hd5, 8'hff, 8'h52);
		chk(cei, 8'h5f);
		wr8(2'h1, 8'hd5, 8'h54);
		m.set_link(1'b0, 1'b0, 6'h3f);
		fse <= 2'h1;
		settle();
		chk(eqs[5:0], 6'h05);
		chk(st[3:0], 4'h4);
		wr8(2'h1, 8'hd4, 8'hb7);
		settle();
		chk({run[0], eqs[5:0]}, 7'h2b);
		chk({run[1], eqs[11:6]}, 7'h40);
		wr8(2'h1, 8'hd4, 8'h10);
		m.set_link(1'b1, 1'b0, 6'h03);
		settle();
		chk({rxl[0], run[0], eqs[5:0]}, 8'h43);
		m.set_link(1'b1, 1'b1, 6'h03);
		settle();
		chk(rxl[0], 1'b1);
		wr8(2'h1, 8'hd4, 8'h00);
		m.set_link(1'b1, 1'b0, 6'h03);
		settle();
		chk(rxl[0], 1'b1);
		print_verdict();
	end
endmodule
`default_nettype wire
